// [hdl/tmr_pkg.sv]
// shared constants, register map and types of the timer/counter/pwm core
package tmr_pkg;

	// common registers, byte addresses
	localparam logic [11:0] TMR_ENA_CTRL_OFS = 12'h000;
	localparam logic [11:0] TMR_ENA_SET_OFS = 12'h004;
	localparam logic [11:0] TMR_ENA_CLR_OFS = 12'h008;
	localparam logic [11:0] TMR_IRQ_SUM_OFS = 12'h00C;
	// channel blocks start here, one block of 32 bytes per channel
	localparam logic [11:0] TMR_CH_BASE = 12'h100;
	localparam int unsigned TMR_CH_SHIFT = 5;
	localparam logic [4:0] TMR_CH_CTRL_OFS = 5'h00;
	localparam logic [4:0] TMR_CH_COUNT_OFS = 5'h04;
	localparam logic [4:0] TMR_CH_CC_OFS = 5'h08;
	localparam logic [4:0] TMR_CH_PERIOD_OFS = 5'h0C;
	localparam logic [4:0] TMR_CH_INTR_OFS = 5'h10;
	localparam logic [4:0] TMR_CH_CMD_OFS = 5'h14;
	localparam logic [4:0] TMR_CH_STAT_OFS = 5'h18;

	// channel_control field positions
	localparam int unsigned TMR_MODE_LSB = 0;
	localparam int unsigned TMR_DIR_LSB = 4;
	localparam int unsigned TMR_PRESC_LSB = 8;
	localparam int unsigned TMR_EDGE_BIT = 12;
	// command and interrupt bit positions
	localparam int unsigned TMR_CMD_RELOAD = 0;
	localparam int unsigned TMR_CMD_START = 1;
	localparam int unsigned TMR_CMD_STOP = 2;
	localparam int unsigned TMR_CMD_CAPTURE = 3;
	localparam int unsigned TMR_INTR_TC = 0;
	localparam int unsigned TMR_INTR_CC = 1;

	// reset values and counts
	localparam logic [31:0] TMR_PERIOD_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] TMR_CC_RST = 32'h0000_0000;
	localparam logic [1:0] TMR_TRIG_SYS_CYCLES = 2'h2;
	localparam int unsigned TMR_MAX_CH = 32;

	typedef enum logic [2:0] {
		MODE_TIMER,
		MODE_CAPTURE,
		MODE_QUAD,
		MODE_PWM,
		MODE_PWM_DT,
		MODE_PWM_PR
	} tmr_mode_t;

	typedef enum logic [1:0] {
		DIR_UP,
		DIR_DOWN,
		DIR_UPDN
	} tmr_dir_t;

	// channel configuration as held in channel_control
	typedef struct packed {
		logic edge_cnt;
		logic [2:0] presc;
		tmr_dir_t dir;
		tmr_mode_t mode;
	} tmr_cfg_t;

endpackage : tmr_pkg

// [hdl/tmr_core.sv]
// multi-channel timer, counter and pwm core with apb register access
`timescale 1ns/1ps
module tmr_core
	import tmr_pkg::*;
#(
	parameter int unsigned NCH = 4,
	parameter int unsigned CW = 16
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// clock strobes
	input wire logic [NCH-1:0] cnt_clk_en_i,
	input wire logic sys_tick_i,
	// per-channel event inputs
	input wire logic [NCH-1:0] count_in_i,
	input wire logic [NCH-1:0] capture_in_i,
	input wire logic [NCH-1:0] reload_i,
	input wire logic [NCH-1:0] start_i,
	input wire logic [NCH-1:0] stop_i,
	// per-channel outputs
	output logic [NCH-1:0] wave_o,
	output logic [NCH-1:0] wave_n_o,
	output logic [NCH-1:0] overflow_o,
	output logic [NCH-1:0] underflow_o,
	output logic [NCH-1:0] cc_trig_o,
	output logic [NCH-1:0] irq_o
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// prescaler wraps when the low sel bits of its counter are all ones
	function automatic logic presc_hit(input logic [6:0] cnt,
		input logic [2:0] sel);
		logic [6:0] mask;
		mask = 7'((8'h01 << sel) - 8'h01);
		return (cnt & mask) == mask;
	endfunction : presc_hit

	// pseudo-random sequence step, never stuck since zero maps to one
	function automatic logic [CW-1:0] lfsr_next(input logic [CW-1:0] v);
		return {v[CW-2:0], ~(v[CW-1] ^ v[CW-2] ^ v[0])};
	endfunction : lfsr_next

	////////////////////////////////////////////////////////////////////////
	// state

	logic [NCH-1:0] en_r; // channel_enable_control
	tmr_cfg_t cfg_r [NCH];
	logic [CW-1:0] count_r [NCH];
	logic [CW-1:0] cc_r [NCH];
	logic [CW-1:0] period_r [NCH];
	logic [1:0] intr_r [NCH];
	logic [NCH-1:0] run_r;
	logic [NCH-1:0] up_r;
	logic [6:0] pre_r [NCH];
	logic [NCH-1:0] pend_r;
	logic [NCH-1:0] cin_q_r;
	logic [NCH-1:0] cap_q_r;
	logic [1:0] left_r [NCH][3];
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;

	logic [11:0] ch_off;
	logic [5:0] ch_sel;
	logic in_ch;
	logic addr_ok;
	logic wr_go;
	logic [31:0] rd_val;
	logic [NCH-1:0] cin_rise;
	logic [NCH-1:0] cap_rise;
	logic [NCH-1:0] ptick;
	logic [NCH-1:0] step;
	logic [NCH-1:0] going_up;
	logic [NCH-1:0] up_nxt;
	logic [NCH-1:0] ov_ev;
	logic [NCH-1:0] un_ev;
	logic [NCH-1:0] cc_ev;
	logic [NCH-1:0] cap_ev;
	logic [NCH-1:0] wr_count;
	logic [NCH-1:0] do_reload;
	logic [NCH-1:0] do_start;
	logic [NCH-1:0] do_stop;
	logic [CW-1:0] count_nxt [NCH];
	logic [1:0] intr_nxt [NCH];

	assign cin_rise = count_in_i & ~cin_q_r;
	assign cap_rise = capture_in_i & ~cap_q_r;

	////////////////////////////////////////////////////////////////////////
	// apb decode, one wait state so read data comes from a flop

	always_comb
	begin
		ch_off = paddr_i - TMR_CH_BASE;
		ch_sel = ch_off[10:TMR_CH_SHIFT];
		// bit 11 of the offset set means far above the last channel block
		in_ch = (paddr_i >= TMR_CH_BASE) && !ch_off[11]
			&& (int'(ch_sel) < NCH);
		addr_ok = 1'b0;
		if (paddr_i[1:0] == 2'h0)
		begin
			if (in_ch)
				addr_ok = ch_off[4:0] <= TMR_CH_STAT_OFS;
			else
				addr_ok = paddr_i <= TMR_IRQ_SUM_OFS;
		end
		wr_go = psel_i && penable_i && pwrite_i && pready_r && !pslverr_r;
	end

	// read mux
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (in_ch)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (ch_sel == 6'(c))
				begin
					case (ch_off[4:0])
						// read back in the same field layout as written
						TMR_CH_CTRL_OFS:
							rd_val = (32'(cfg_r[c].edge_cnt) << TMR_EDGE_BIT)
								| (32'(cfg_r[c].presc) << TMR_PRESC_LSB)
								| (32'(cfg_r[c].dir) << TMR_DIR_LSB)
								| (32'(cfg_r[c].mode) << TMR_MODE_LSB);
						TMR_CH_COUNT_OFS: rd_val = 32'(count_r[c]);
						TMR_CH_CC_OFS: rd_val = 32'(cc_r[c]);
						TMR_CH_PERIOD_OFS: rd_val = 32'(period_r[c]);
						TMR_CH_INTR_OFS: rd_val = 32'(intr_r[c]);
						TMR_CH_STAT_OFS: rd_val = {30'h0, up_r[c], run_r[c]};
						default: rd_val = 32'h0000_0000;
					endcase
				end
			end
		end
		else if (paddr_i == TMR_ENA_CTRL_OFS || paddr_i == TMR_ENA_SET_OFS)
			rd_val = 32'(en_r);
		else if (paddr_i == TMR_IRQ_SUM_OFS)
			rd_val = 32'(irq_o);
	end

	// access phase: answer on the second access cycle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= psel_i && penable_i && !pready_r;
			pslverr_r <= psel_i && penable_i && !pready_r && !addr_ok;
			if (psel_i && penable_i && !pready_r && !pwrite_i && addr_ok)
				prdata_r <= rd_val;
		end
	end

	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign prdata_o = prdata_r;

	////////////////////////////////////////////////////////////////////////
	// enable register, set and clear in one edge so no rmw race

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			en_r <= '0;
		else if (wr_go && paddr_i == TMR_ENA_SET_OFS)
			en_r <= en_r | pwdata_i[NCH-1:0];
		else if (wr_go && paddr_i == TMR_ENA_CLR_OFS)
			en_r <= en_r & ~pwdata_i[NCH-1:0];
		else if (wr_go && paddr_i == TMR_ENA_CTRL_OFS)
			en_r <= pwdata_i[NCH-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel writes and commands

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			logic hit;
			logic cmd;
			hit = wr_go && in_ch && ch_sel == 6'(c);
			cmd = hit && ch_off[4:0] == TMR_CH_CMD_OFS;
			wr_count[c] = hit && ch_off[4:0] == TMR_CH_COUNT_OFS;
			do_stop[c] = stop_i[c] || (cmd && pwdata_i[TMR_CMD_STOP]);
			// stop suppresses reload and start, reload suppresses start
			do_reload[c] = !do_stop[c] && (reload_i[c]
				|| (cmd && pwdata_i[TMR_CMD_RELOAD]));
			do_start[c] = !do_stop[c] && !do_reload[c] && (start_i[c]
				|| (cmd && pwdata_i[TMR_CMD_START]));
			cap_ev[c] = en_r[c] && run_r[c]
				&& cfg_r[c].mode == MODE_CAPTURE
				&& (cap_rise[c] || (cmd && pwdata_i[TMR_CMD_CAPTURE]));
		end
	end

	// configuration is untouched by enable changes
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				cfg_r[c] <= '0;
				period_r[c] <= TMR_PERIOD_RST[CW-1:0];
				cc_r[c] <= TMR_CC_RST[CW-1:0];
			end
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (wr_go && in_ch && ch_sel == 6'(c))
				begin
					if (ch_off[4:0] == TMR_CH_CTRL_OFS)
					begin
						cfg_r[c].mode <= tmr_mode_t'(pwdata_i[TMR_MODE_LSB +: 3]);
						cfg_r[c].dir <= tmr_dir_t'(pwdata_i[TMR_DIR_LSB +: 2]);
						cfg_r[c].presc <= pwdata_i[TMR_PRESC_LSB +: 3];
						cfg_r[c].edge_cnt <= pwdata_i[TMR_EDGE_BIT];
					end
					if (ch_off[4:0] == TMR_CH_PERIOD_OFS)
						period_r[c] <= pwdata_i[CW-1:0];
					if (ch_off[4:0] == TMR_CH_CC_OFS)
						cc_r[c] <= pwdata_i[CW-1:0];
				end
				if (cap_ev[c])
					cc_r[c] <= count_r[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counting engine

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			tmr_mode_t m;
			logic qual;
			m = cfg_r[c].mode;
			ptick[c] = cnt_clk_en_i[c] && (m == MODE_QUAD
				|| m == MODE_PWM_DT || presc_hit(pre_r[c], cfg_r[c].presc));
			qual = cfg_r[c].edge_cnt ? (pend_r[c] || cin_rise[c])
				: count_in_i[c];
			case (m)
				MODE_QUAD: step[c] = cnt_clk_en_i[c]
					&& (pend_r[c] || cin_rise[c]);
				MODE_PWM_PR: step[c] = cnt_clk_en_i[c];
				default: step[c] = ptick[c] && qual;
			endcase
			step[c] = step[c] && en_r[c] && run_r[c];
			if (m == MODE_QUAD)
				going_up[c] = !capture_in_i[c];
			else
				going_up[c] = cfg_r[c].dir == DIR_UP
					|| (cfg_r[c].dir == DIR_UPDN && up_r[c]);
			up_nxt[c] = up_r[c];
			ov_ev[c] = 1'b0;
			un_ev[c] = 1'b0;
			count_nxt[c] = count_r[c];
			if (m == MODE_PWM_PR)
			begin
				count_nxt[c] = lfsr_next(count_r[c]);
				ov_ev[c] = count_r[c] == period_r[c];
			end
			else if (going_up[c])
			begin
				if (count_r[c] == period_r[c])
				begin
					ov_ev[c] = 1'b1;
					if (cfg_r[c].dir == DIR_UPDN && m != MODE_QUAD)
					begin
						count_nxt[c] = count_r[c] - CW'(1);
						up_nxt[c] = 1'b0;
					end
					else
						count_nxt[c] = '0;
				end
				else
					count_nxt[c] = count_r[c] + CW'(1);
			end
			else
			begin
				if (count_r[c] == '0)
				begin
					un_ev[c] = 1'b1;
					if (cfg_r[c].dir == DIR_UPDN && m != MODE_QUAD)
					begin
						count_nxt[c] = count_r[c] + CW'(1);
						up_nxt[c] = 1'b1;
					end
					else
						count_nxt[c] = period_r[c];
				end
				else
					count_nxt[c] = count_r[c] - CW'(1);
			end
			ov_ev[c] = ov_ev[c] && step[c];
			un_ev[c] = un_ev[c] && step[c];
			cc_ev[c] = cap_ev[c] || (m != MODE_CAPTURE && step[c]
				&& count_nxt[c] == cc_r[c] && count_r[c] != cc_r[c]);
		end
	end

	// counter, direction and run state; software write wins over counting
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			run_r <= '0;
			up_r <= '1;
			for (int c = 0; c < NCH; c++)
				count_r[c] <= '0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (do_stop[c])
					run_r[c] <= 1'b0;
				else if (do_reload[c] || do_start[c])
					run_r[c] <= 1'b1;
				if (wr_count[c])
					count_r[c] <= pwdata_i[CW-1:0];
				else if (do_reload[c])
				begin
					count_r[c] <= cfg_r[c].dir == DIR_DOWN ? period_r[c] : '0;
					up_r[c] <= cfg_r[c].dir != DIR_DOWN;
				end
				else if (step[c])
				begin
					count_r[c] <= count_nxt[c];
					up_r[c] <= up_nxt[c];
				end
			end
		end
	end

	// prescaler and edge capture; the consuming tick clears a pending edge even when a new edge arrives
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pend_r <= '0;
			cin_q_r <= '0;
			cap_q_r <= '0;
			for (int c = 0; c < NCH; c++)
				pre_r[c] <= '0;
		end
		else
		begin
			cin_q_r <= count_in_i;
			cap_q_r <= capture_in_i;
			for (int c = 0; c < NCH; c++)
			begin
				if (do_reload[c])
					pre_r[c] <= '0;
				else if (cnt_clk_en_i[c] && en_r[c] && run_r[c])
					pre_r[c] <= pre_r[c] + 7'h01;
				if (cfg_r[c].mode == MODE_QUAD ? cnt_clk_en_i[c] : ptick[c])
					pend_r[c] <= 1'b0;
				else if (cin_rise[c])
					pend_r[c] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: wave, trigger pulses, interrupt flags

	// pwm modes compare count to cc, other modes toggle on terminal count
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wave_o <= '0;
			wave_n_o <= '1;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (en_r[c] && (cfg_r[c].mode == MODE_PWM
					|| cfg_r[c].mode == MODE_PWM_DT
					|| cfg_r[c].mode == MODE_PWM_PR))
				begin
					wave_o[c] <= count_r[c] < cc_r[c];
					wave_n_o[c] <= !(count_r[c] < cc_r[c]);
				end
				else if (ov_ev[c] || un_ev[c])
				begin
					wave_o[c] <= !wave_o[c];
					wave_n_o[c] <= wave_o[c];
				end
			end
		end
	end

	// each trigger is held for two system clock strobes
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			overflow_o <= '0;
			underflow_o <= '0;
			cc_trig_o <= '0;
			for (int c = 0; c < NCH; c++)
				for (int t = 0; t < 3; t++)
					left_r[c][t] <= '0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				logic [2:0] ev;
				logic [2:0] q;
				ev = {cc_ev[c], un_ev[c], ov_ev[c]};
				q = {cc_trig_o[c], underflow_o[c], overflow_o[c]};
				for (int t = 0; t < 3; t++)
				begin
					if (!en_r[c])
					begin
						q[t] = 1'b0;
						left_r[c][t] <= '0;
					end
					else if (ev[t])
					begin
						q[t] = 1'b1;
						left_r[c][t] <= TMR_TRIG_SYS_CYCLES;
					end
					else if (sys_tick_i && q[t])
					begin
						left_r[c][t] <= left_r[c][t] - 2'h1;
						if (left_r[c][t] == 2'h1)
							q[t] = 1'b0;
					end
				end
				overflow_o[c] <= q[0];
				underflow_o[c] <= q[1];
				cc_trig_o[c] <= q[2];
			end
		end
	end

	// sticky flags, a new event beats a write-one clear
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			intr_nxt[c] = intr_r[c];
			if (wr_go && in_ch && ch_sel == 6'(c)
				&& ch_off[4:0] == TMR_CH_INTR_OFS)
				intr_nxt[c] = intr_r[c] & ~pwdata_i[1:0];
			intr_nxt[c][TMR_INTR_TC] = intr_nxt[c][TMR_INTR_TC]
				|| ov_ev[c] || un_ev[c];
			intr_nxt[c][TMR_INTR_CC] = intr_nxt[c][TMR_INTR_CC] || cc_ev[c];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_o <= '0;
			for (int c = 0; c < NCH; c++)
				intr_r[c] <= '0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				intr_r[c] <= intr_nxt[c];
				irq_o[c] <= |intr_nxt[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions on channel 0

	logic [1:0] hi_ticks_r; // system strobes seen while overflow is high
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			hi_ticks_r <= '0;
		else if (!overflow_o[0] || ov_ev[0])
			hi_ticks_r <= '0;
		else if (sys_tick_i && hi_ticks_r != 2'h3)
			hi_ticks_r <= hi_ticks_r + 2'h1;
	end

	property p_trig_width;
		@(posedge clk_i) disable iff (!arst_n_i)
		overflow_o[0] |-> hi_ticks_r < 2'h2;
	endproperty
	a_trig_width: assert property (p_trig_width)
		else $error("overflow trigger held past two system strobes");

	property p_trig_fall;
		@(posedge clk_i) disable iff (!arst_n_i)
		$fell(overflow_o[0]) && $past(en_r[0]) |-> $past(hi_ticks_r) == 2'h1
			&& $past(sys_tick_i);
	endproperty
	a_trig_fall: assert property (p_trig_fall)
		else $error("overflow trigger dropped early");

	property p_stop_prio;
		@(posedge clk_i) disable iff (!arst_n_i)
		stop_i[0] && (reload_i[0] || start_i[0]) |=> !run_r[0];
	endproperty
	a_stop_prio: assert property (p_stop_prio)
		else $error("stop did not win over reload or start");

	property p_ena_set;
		@(posedge clk_i) disable iff (!arst_n_i)
		wr_go && paddr_i == TMR_ENA_SET_OFS && pwdata_i[0] |=> en_r[0];
	endproperty
	a_ena_set: assert property (p_ena_set)
		else $error("enable set write ignored");

	property p_ena_atomic;
		@(posedge clk_i) disable iff (!arst_n_i)
		wr_go && (paddr_i == TMR_ENA_SET_OFS || paddr_i == TMR_ENA_CLR_OFS)
			&& !pwdata_i[0] |=> $stable(en_r[0]);
	endproperty
	a_ena_atomic: assert property (p_ena_atomic)
		else $error("zero bit of set or clear disturbed another channel");

	property p_cfg_kept;
		@(posedge clk_i) disable iff (!arst_n_i)
		$fell(en_r[0]) |-> $stable(cfg_r[0]) && $stable(period_r[0]);
	endproperty
	a_cfg_kept: assert property (p_cfg_kept)
		else $error("disable changed configuration");

	property p_hold_off;
		@(posedge clk_i) disable iff (!arst_n_i)
		!en_r[0] && !wr_count[0] && !do_reload[0] |=> $stable(count_r[0])
			&& !overflow_o[0] && !cc_trig_o[0];
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("disabled channel moved or triggered");

	property p_level_gate;
		@(posedge clk_i) disable iff (!arst_n_i)
		cfg_r[0].mode == MODE_TIMER && !cfg_r[0].edge_cnt && !count_in_i[0]
			&& !wr_count[0] && !do_reload[0] |=> $stable(count_r[0]);
	endproperty
	a_level_gate: assert property (p_level_gate)
		else $error("counted while level count input low");

	property p_ovf_wrap;
		@(posedge clk_i) disable iff (!arst_n_i)
		step[0] && cfg_r[0].mode == MODE_TIMER && cfg_r[0].dir == DIR_UP
			&& count_r[0] == period_r[0] && !wr_count[0] && !do_reload[0]
			|=> count_r[0] == '0 && overflow_o[0] && intr_r[0][TMR_INTR_TC];
	endproperty
	a_ovf_wrap: assert property (p_ovf_wrap)
		else $error("overflow at period not signalled");

	c_overflow: cover property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(overflow_o[0]));
	c_underflow: cover property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(underflow_o[0]));
	c_capture: cover property (@(posedge clk_i) disable iff (!arst_n_i)
		cap_ev[0]);
	c_irq: cover property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(irq_o[0]));

endmodule : tmr_core

// [verif/tmr_sink.sv]
// trigger consumer model: measures pulse width and spacing of one trigger
`timescale 1ns/1ps
module tmr_sink (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// watched trigger and measurement clear
	input wire logic trig_i,
	input wire logic clr_i,
	// measurements
	output logic [7:0] width_o,
	output logic [7:0] gap_o,
	output logic [3:0] rises_o
);
	logic prev_r;
	logic [7:0] hi_r;
	logic [7:0] since_r;
	////////////////////////////////////////////////////////////////////////
	// a peripheral only samples triggers, it never pushes back
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i || clr_i)
		begin
			prev_r <= 1'b0;
			hi_r <= 8'h00;
			since_r <= 8'h00;
			width_o <= 8'h00;
			gap_o <= 8'h00;
			rises_o <= 4'h0;
		end
		else
		begin
			prev_r <= trig_i;
			hi_r <= trig_i ? hi_r + 8'h01 : 8'h00;
			since_r <= (trig_i && !prev_r) ? 8'h01 : since_r + 8'h01;
			if (trig_i && !prev_r)
			begin
				gap_o <= since_r;
				rises_o <= rises_o + 4'h1;
			end
			if (!trig_i && prev_r)
				width_o <= hi_r;
		end
	end
endmodule : tmr_sink

// [verif/test_timer_counter_pwm_core.sv]
// self-checking bench of the timer/counter/pwm core
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_timer_counter_pwm_core;
	import tmr_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, err, clr = 1'b0, dsel = 1'b0, tick = 1'b1;
	logic [3:0] count_in_i = 4'h0, reload_i = 4'h0, stop_i = 4'h0;
	logic [3:0] capture_in_i = 4'h0, start_i = 4'h0;
	logic [3:0] wave_o, wave_n_o, overflow_o, underflow_o, cc_trig_o, irq_o;
	logic [7:0] width, gap;
	logic [3:0] rises;
	int fails = 0, cmp_count = 0;
	always #4 clk_i = ~clk_i;
	tmr_core #(.NCH(4), .CW(16)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .cnt_clk_en_i(4'hF),
		.sys_tick_i(tick), .count_in_i(count_in_i),
		.capture_in_i(capture_in_i),
		.reload_i(reload_i), .start_i(start_i), .stop_i(stop_i),
		.wave_o(wave_o), .wave_n_o(wave_n_o), .overflow_o(overflow_o),
		.underflow_o(underflow_o), .cc_trig_o(cc_trig_o), .irq_o(irq_o));
	tmr_sink SINK (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.trig_i(dsel ? underflow_o[0] : overflow_o[0]), .clr_i(clr),
		.width_o(width), .gap_o(gap), .rises_o(rises));
	////////////////////////////////////////////////////////////////////////
	// verdict, reached from the main flow or from a used-up wait
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// one apb transfer; waits for pready under a bound, never assumes latency
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			tally_and_finish();
		end
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	function automatic logic [11:0] ca(input int c, input logic [4:0] o);
		return TMR_CH_BASE + 12'(c << TMR_CH_SHIFT) + {7'h00, o};
	endfunction : ca
	////////////////////////////////////////////////////////////////////////
	// reset values, count write/readback, unmapped address
	task t_regs;
		apb(0, ca(0, TMR_CH_PERIOD_OFS), 0);
		`CHK("period rst", 32'h0000FFFF, q)
		apb(1, ca(0, TMR_CH_COUNT_OFS), 32'h0000_1234);
		apb(0, ca(0, TMR_CH_COUNT_OFS), 0);
		`CHK("count rw", 32'h0000_1234, q)
		apb(0, 12'h0F0, 0);
		`CHK("unmapped err", 1'b1, err)
		$display("test regs done");
	endtask : t_regs
	// set/clear act only on ones; config survives disable
	task t_enable;
		apb(1, ca(2, TMR_CH_PERIOD_OFS), 32'h9);
		apb(1, TMR_ENA_SET_OFS, 32'h5);
		apb(1, TMR_ENA_SET_OFS, 32'h2);
		apb(0, TMR_ENA_CTRL_OFS, 0);
		`CHK("enable set", 32'h7, q)
		apb(1, TMR_ENA_CLR_OFS, 32'h1);
		apb(0, TMR_ENA_CTRL_OFS, 0);
		`CHK("enable clr", 32'h6, q)
		apb(1, TMR_ENA_CLR_OFS, 32'hF);
		apb(0, ca(2, TMR_CH_PERIOD_OFS), 0);
		`CHK("period kept", 32'h9, q)
		$display("test enable done");
	endtask : t_enable
	// capture pin snapshots a frozen count into compare value
	task t_capture;
		apb(1, ca(3, TMR_CH_CTRL_OFS), 32'(MODE_CAPTURE) << TMR_MODE_LSB);
		apb(1, ca(3, TMR_CH_COUNT_OFS), 32'h0000_0042);
		apb(1, ca(3, TMR_CH_CMD_OFS), 32'h1 << TMR_CMD_START);
		apb(1, TMR_ENA_SET_OFS, 32'h8);
		capture_in_i <= 4'h8;
		@(posedge clk_i);
		capture_in_i <= 4'h0;
		@(posedge clk_i);
		`CHK("cc trig", 1'b1, cc_trig_o[3])
		`CHK("cc irq", 1'b1, irq_o[3])
		apb(0, ca(3, TMR_CH_CC_OFS), 0);
		`CHK("captured", 32'h0000_0042, q)
		apb(0, ca(3, TMR_CH_INTR_OFS), 0);
		`CHK("cc flag", 32'h2, q)
		apb(0, TMR_IRQ_SUM_OFS, 0);
		`CHK("irq sum", 32'h8, q)
		apb(1, TMR_ENA_CLR_OFS, 32'h8);
		$display("test capture done");
	endtask : t_capture
	// gating by count input, stop beating reload, hold while disabled
	task t_gate;
		apb(1, ca(1, TMR_CH_COUNT_OFS), 32'h5);
		apb(1, ca(1, TMR_CH_CMD_OFS), 32'h1 << TMR_CMD_START);
		apb(1, TMR_ENA_SET_OFS, 32'h2);
		repeat (20) @(posedge clk_i);
		apb(0, ca(1, TMR_CH_COUNT_OFS), 0);
		`CHK("no count", 32'h5, q)
		reload_i <= 4'h3;
		start_i <= 4'h3;
		stop_i <= 4'h3;
		@(posedge clk_i);
		reload_i <= 4'h0;
		start_i <= 4'h0;
		stop_i <= 4'h0;
		apb(0, ca(1, TMR_CH_STAT_OFS), 0);
		`CHK("stopped", 32'h2, q)
		apb(0, ca(1, TMR_CH_COUNT_OFS), 0);
		`CHK("stop wins", 32'h5, q)
		// restart by pin so the hold below is due to disable alone
		start_i <= 4'h2;
		@(posedge clk_i);
		start_i <= 4'h0;
		apb(0, ca(1, TMR_CH_STAT_OFS), 0);
		`CHK("started", 32'h3, q)
		apb(1, TMR_ENA_CLR_OFS, 32'h2);
		count_in_i <= 4'hF;
		repeat (20) @(posedge clk_i);
		apb(0, ca(1, TMR_CH_COUNT_OFS), 0);
		`CHK("held count", 32'h5, q)
		`CHK("no trig", 1'b0, overflow_o[1])
		$display("test gate done");
	endtask : t_gate
	// period n-1, prescale and direction seen in trigger spacing and width
	task automatic t_run(input logic dn, input logic [2:0] ps);
		int n;
		logic w0;
		logic [31:0] cw;
		cw = (32'(ps) << TMR_PRESC_LSB) | (32'(dn) << TMR_DIR_LSB);
		dsel <= dn;
		apb(1, ca(0, TMR_CH_CTRL_OFS), cw);
		apb(0, ca(0, TMR_CH_CTRL_OFS), 0);
		`CHK("ctrl rd", cw, q)
		apb(1, ca(0, TMR_CH_PERIOD_OFS), 32'h3);
		apb(1, ca(0, TMR_CH_CMD_OFS), 32'h1 << TMR_CMD_RELOAD);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		w0 = wave_o[0];
		apb(1, TMR_ENA_SET_OFS, 32'h1);
		for (n = 0; n < 300 && rises < 4'h3; n++)
			@(posedge clk_i);
		if (rises < 4'h3)
		begin
			fails++;
			tally_and_finish();
		end
		`CHK("gap", 8'(4 << ps), gap)
		`CHK("width", 8'h02, width)
		`CHK("wave", ~w0, wave_o[0])
		`CHK("wave_n", w0, wave_n_o[0])
		`CHK("irq", 1'b1, irq_o[0])
		apb(1, TMR_ENA_CLR_OFS, 32'h1);
		apb(0, ca(0, TMR_CH_INTR_OFS), 0);
		`CHK("flags", 32'h3, q)
		apb(1, ca(0, TMR_CH_INTR_OFS), 32'h3);
		repeat (3) @(posedge clk_i);
		`CHK("irq clr", 1'b0, irq_o[0])
		$display("test run dir %0d presc %0d done", dn, ps);
	endtask : t_run
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_enable();
		t_capture();
		t_gate();
		t_run(1'b0, 3'h0);
		t_run(1'b0, 3'h2);
		t_run(1'b1, 3'h1);
		tally_and_finish();
	end
endmodule : test_timer_counter_pwm_core
